// ---- msp_regs.vh ----
// Constants for the motor start supervision block
`ifndef MSP_REGS_VH
`define MSP_REGS_VH

// Clock and millisecond tick
`define MSP_CLK_PERIOD_NS   32'h0000_000A
`define MSP_TICK_NS         32'h000F_4240
`define MSP_CNT_RST         32'h0000_0000
`define MSP_CNT_ONE         32'h0000_0001

// Current levels, percent of motor nominal current; phase sequence ratio in percent of positive sequence current
`define MSP_STOP_PCT        16'h000A
`define MSP_RUN_LO_PCT      16'h0014
`define MSP_RUN_HI_PCT      16'h0078
`define MSP_PS_RATIO_PCT    16'h0050

// Durations in milliseconds
`define MSP_PS_TRIP_MS      16'h0064
`define MSP_RISE_WIN_MS     16'h00C8
`define MSP_STOP_MIN_MS     16'h01F4

// Setting reset values per group
`define MSP_DEF_START_LVL   16'h0258
`define MSP_DEF_RATED_START 16'h0258
`define MSP_DEF_DT_MS       16'h1388
`define MSP_DEF_INV_MS      16'h2710
`define MSP_DEF_FIXED_MODE  1'b1

// Setting field selects on the configuration write port
`define MSP_FLD_START_LVL   3'h0
`define MSP_FLD_RATED_START 3'h1
`define MSP_FLD_DT_TIME     3'h2
`define MSP_FLD_INV_TIME    3'h3
`define MSP_FLD_FIXED_MODE  3'h4

// Group codes
`define MSP_GRP_DEFAULT     2'h0

// Voltage sequence indication
`define MSP_VSEQ_OK         2'h0
`define MSP_VSEQ_REV        2'h1
`define MSP_VSEQ_UNK        2'h2
`define MSP_VSEQ_MIN        16'h0064

// Arithmetic
`define MSP_PCT_SCALE       64'h0000_0000_0000_0064
`define MSP_PCT_SAT         16'hFFFF
`define MSP_ZERO16          16'h0000
`define MSP_ONE16           16'h0001
`define MSP_DIV_STEPS       7'h40
`define MSP_DIV_LAST        7'h01

`endif

// ---- msp_div.v ----
// Serial divider giving a 16-bit saturated quotient
`timescale 1ns/100ps
`include "msp_regs.vh"

module msp_div (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // Operands
  input  wire        start,
  input  wire [63:0] num,
  input  wire [63:0] den,
  // Result
  output reg         done,
  output reg  [15:0] quot
);

  reg         busy_q;
  reg  [6:0]  cnt_q;
  reg  [63:0] rem_q;
  reg  [63:0] num_q;
  reg  [63:0] den_q;
  reg  [63:0] quo_q;
  wire [63:0] trial;
  wire        fits;
  wire [63:0] quo_d;

  // Operands stay below 2^56, so the shifted remainder never overflows
  assign trial = {rem_q[62:0], num_q[63]};
  assign fits  = (trial >= den_q);
  assign quo_d = {quo_q[62:0], fits};

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 7'h00;
      rem_q  <= 64'h0000_0000_0000_0000;
      num_q  <= 64'h0000_0000_0000_0000;
      den_q  <= 64'h0000_0000_0000_0000;
      quo_q  <= 64'h0000_0000_0000_0000;
      done   <= 1'b0;
      quot   <= `MSP_ZERO16;
    end else begin
      done <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          if (den == 64'h0000_0000_0000_0000) begin
            // No reference: report full scale
            quot <= `MSP_PCT_SAT;
            done <= 1'b1;
          end else begin
            busy_q <= 1'b1;
            cnt_q  <= `MSP_DIV_STEPS;
            rem_q  <= 64'h0000_0000_0000_0000;
            num_q  <= num;
            den_q  <= den;
            quo_q  <= 64'h0000_0000_0000_0000;
          end
        end
      end else begin
        rem_q <= fits ? (trial - den_q) : trial;
        num_q <= {num_q[62:0], 1'b0};
        quo_q <= quo_d;
        cnt_q <= cnt_q - 7'h01;
        if (cnt_q == `MSP_DIV_LAST) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          quot   <= (quo_d[63:16] != 48'h0000_0000_0000) ? `MSP_PCT_SAT : quo_d[15:0];
        end
      end
    end
  end

endmodule

// ---- msp_top.v ----
// Motor start supervision: phase sequence, stall stage and motor state
//
// Overview of operation
// - Phase sequence starts above 80% current ratio, trips after 100 ms.
// - Phase sequence measured value is negative over positive current in percent.
// - Each stage counts start events and trip events separately.
// - Elapsed fault delay is recorded as percent of operate time, 100% trips.
// - Output sequence voltages, their ratio and OK/reversed/unknown indication.
// - Stall delay selectable as definite time or inverse time.
// - Stall timing begins after current below 10% rises past detection within 200 ms.
// - Inverse stall time is start time times squared rated-over-measured current.
// - Stall stage releases when current falls below 120% of nominal.
// - Stall stage works only while the motor is starting.
// - Rated starting current setting defaults to 6.00 times nominal.
// - Motor condition is one of stopped, starting or running.
// - Motor is stopped whenever average current is below 10% of nominal.
// - Starting needs 500 ms stopped, then detection crossed within 200 ms.
// - Running entered from stopped or starting with current in 20%..120%.
// - A soft start passes from stopped straight to running.
// - Motor status feeds the output and blocking matrices.
// - Each stage is blockable by status, digital or virtual inputs.
// - Setting group one to four chosen by any digital input, default one.
// - Start detection level defaults to six times nominal current.
`timescale 1ns/100ps
`include "msp_regs.vh"

module msp_top #(
  parameter [31:0] TICK_CYCLES = `MSP_TICK_NS / `MSP_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // Measurement front end, currents in percent of motor nominal
  input  wire [15:0] motor_current,
  input  wire [15:0] neg_seq_current,
  input  wire [15:0] pos_seq_current,
  input  wire [15:0] pos_seq_voltage,
  input  wire [15:0] neg_seq_voltage,
  // Setting write port and group selection
  input  wire        cfg_wr_en,
  input  wire [1:0]  cfg_group,
  input  wire [2:0]  cfg_field,
  input  wire [15:0] cfg_data,
  input  wire        grp_sel_enable,
  input  wire [2:0]  grp_sel_input,
  input  wire [1:0]  grp_sel_target,
  input  wire        counter_clear,
  // Matrix sources and masks
  input  wire [7:0]  digital_inputs,
  input  wire [3:0]  virtual_inputs,
  input  wire [14:0] ps_block_mask,
  input  wire [14:0] stall_block_mask,
  input  wire [27:0] output_matrix_mask,
  // Motor status
  output wire        motor_stopped,
  output wire        motor_starting,
  output wire        motor_running,
  output reg  [1:0]  active_group,
  // Phase sequence stage
  output reg         ps_start,
  output reg         ps_trip,
  output reg  [15:0] ps_ratio_percent,
  output wire [15:0] ps_start_event_counter,
  output wire [15:0] ps_trip_event_counter,
  output reg  [15:0] ps_elapsed_delay_percent,
  // Stall stage
  output reg         stall_start,
  output reg         stall_trip,
  output wire [15:0] stall_start_event_counter,
  output wire [15:0] stall_trip_event_counter,
  output reg  [15:0] stall_elapsed_delay_percent,
  output reg  [15:0] measured_start_current,
  // Voltage sequence indication
  output reg  [15:0] pos_seq_voltage_out,
  output reg  [15:0] neg_seq_voltage_out,
  output reg  [15:0] voltage_ratio_percent,
  output reg  [1:0]  voltage_seq_status,
  // Output matrix relays
  output reg  [3:0]  output_relays
);

  localparam [1:0] ST_STOPPED  = 2'b00;
  localparam [1:0] ST_STARTING = 2'b01;
  localparam [1:0] ST_RUNNING  = 2'b10;

  reg  [31:0] tick_cnt_q;
  reg         tick_q;
  reg  [15:0] start_lvl_q   [0:3];
  reg  [15:0] rated_start_q [0:3];
  reg  [15:0] dt_time_q     [0:3];
  reg  [15:0] inv_time_q    [0:3];
  reg         fixed_mode_q  [0:3];
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [15:0] stopped_ms_q;
  reg  [15:0] rise_ms_q;
  reg  [15:0] ps_ms_q;
  reg  [15:0] stall_ms_q;
  reg  [1:0]  start_prev_q;
  reg  [1:0]  trip_prev_q;
  reg  [15:0] start_cnt_q [0:1];
  reg  [15:0] trip_cnt_q  [0:1];

  wire [15:0] set_start_lvl;
  wire [15:0] set_rated;
  wire [15:0] set_dt;
  wire [15:0] set_inv;
  wire        set_fixed;
  wire [14:0] blk_src;
  wire        ps_blocked;
  wire        stall_blocked;
  wire        cur_low;
  wire        cur_in_run;
  wire        cur_above_det;
  wire        rise_ok;
  wire        ps_cond;
  wire        stall_cond;
  wire [63:0] cur_sq;
  wire [63:0] rated_sq_t;
  wire [63:0] stall_weighted;
  wire        stall_due;
  wire [63:0] stall_num;
  wire [63:0] stall_den;
  wire        cur_div_done;
  wire [15:0] cur_div_q;
  wire        volt_div_done;
  wire [15:0] volt_div_q;
  wire        stall_div_done;
  wire [15:0] stall_div_q;
  wire [1:0]  stage_start;
  wire [1:0]  stage_trip;
  wire [6:0]  out_src;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      tick_cnt_q <= `MSP_CNT_RST;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - `MSP_CNT_ONE) begin
      tick_cnt_q <= `MSP_CNT_RST;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + `MSP_CNT_ONE;
      tick_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting groups
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      localparam [1:0] GI = g;
      always @(posedge ref_clk) begin
        if (!reset_n) begin
          start_lvl_q[g]   <= `MSP_DEF_START_LVL;
          rated_start_q[g] <= `MSP_DEF_RATED_START;
          dt_time_q[g]     <= `MSP_DEF_DT_MS;
          inv_time_q[g]    <= `MSP_DEF_INV_MS;
          fixed_mode_q[g]  <= `MSP_DEF_FIXED_MODE;
        end else if (cfg_wr_en && cfg_group == GI) begin
          case (cfg_field)
            `MSP_FLD_START_LVL:   start_lvl_q[g]   <= cfg_data;
            `MSP_FLD_RATED_START: rated_start_q[g] <= cfg_data;
            `MSP_FLD_DT_TIME:     dt_time_q[g]     <= cfg_data;
            `MSP_FLD_INV_TIME:    inv_time_q[g]    <= cfg_data;
            `MSP_FLD_FIXED_MODE:  fixed_mode_q[g]  <= cfg_data[0];
            default:              fixed_mode_q[g]  <= fixed_mode_q[g];
          endcase
        end
      end
    end
  endgenerate

  // Group one unless the chosen digital input asks for another
  always @(posedge ref_clk) begin
    if (!reset_n)
      active_group <= `MSP_GRP_DEFAULT;
    else if (grp_sel_enable && digital_inputs[grp_sel_input])
      active_group <= grp_sel_target;
    else
      active_group <= `MSP_GRP_DEFAULT;
  end

  assign set_start_lvl = start_lvl_q[active_group];
  assign set_rated     = rated_start_q[active_group];
  assign set_dt        = dt_time_q[active_group];
  assign set_inv       = inv_time_q[active_group];
  assign set_fixed     = fixed_mode_q[active_group];

  ////////////////////////////////////////////////////////////////////////////
  // Blocking matrix
  assign blk_src       = {motor_running, motor_starting, motor_stopped,
                          virtual_inputs, digital_inputs};
  assign ps_blocked    = |(blk_src & ps_block_mask);
  assign stall_blocked = |(blk_src & stall_block_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Motor state
  assign cur_low       = (motor_current < `MSP_STOP_PCT);
  assign cur_in_run    = (motor_current >= `MSP_RUN_LO_PCT) &&
                         (motor_current <= `MSP_RUN_HI_PCT);
  assign cur_above_det = (motor_current > set_start_lvl);
  assign rise_ok       = !cur_low && (rise_ms_q <= `MSP_RISE_WIN_MS);

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      stopped_ms_q <= `MSP_ZERO16;
      rise_ms_q    <= `MSP_ZERO16;
    end else begin
      if (cur_low) begin
        rise_ms_q <= `MSP_ZERO16;
        if (tick_q && stopped_ms_q < `MSP_STOP_MIN_MS)
          stopped_ms_q <= stopped_ms_q + `MSP_ONE16;
      end else begin
        if (state_q != ST_STOPPED)
          stopped_ms_q <= `MSP_ZERO16;
        // Saturates just past the window so it never wraps back inside
        if (tick_q && rise_ms_q <= `MSP_RISE_WIN_MS)
          rise_ms_q <= rise_ms_q + `MSP_ONE16;
      end
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOPPED: begin
        if (!cur_low && cur_above_det && rise_ok && stopped_ms_q >= `MSP_STOP_MIN_MS)
          state_d = ST_STARTING;
        else if (cur_in_run && !rise_ok)
          state_d = ST_RUNNING;
      end
      ST_STARTING: begin
        if (cur_low)
          state_d = ST_STOPPED;
        else if (cur_in_run)
          state_d = ST_RUNNING;
      end
      ST_RUNNING: begin
        if (cur_low)
          state_d = ST_STOPPED;
      end
      default: state_d = ST_STOPPED;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!reset_n)
      state_q <= ST_STOPPED;
    else
      state_q <= state_d;
  end

  assign motor_stopped  = (state_q == ST_STOPPED);
  assign motor_starting = (state_q == ST_STARTING);
  assign motor_running  = (state_q == ST_RUNNING);

  ////////////////////////////////////////////////////////////////////////////
  // Ratio dividers, restarted every millisecond
  msp_div u_cur_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (tick_q),
    .num     ({48'h0000_0000_0000, neg_seq_current} * `MSP_PCT_SCALE),
    .den     ({48'h0000_0000_0000, pos_seq_current}),
    .done    (cur_div_done),
    .quot    (cur_div_q)
  );

  msp_div u_volt_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (tick_q),
    .num     ({48'h0000_0000_0000, neg_seq_voltage} * `MSP_PCT_SCALE),
    .den     ({48'h0000_0000_0000, pos_seq_voltage}),
    .done    (volt_div_done),
    .quot    (volt_div_q)
  );

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ps_ratio_percent      <= `MSP_ZERO16;
      voltage_ratio_percent <= `MSP_ZERO16;
      pos_seq_voltage_out   <= `MSP_ZERO16;
      neg_seq_voltage_out   <= `MSP_ZERO16;
      voltage_seq_status    <= `MSP_VSEQ_UNK;
    end else begin
      if (cur_div_done)
        ps_ratio_percent <= cur_div_q;
      if (volt_div_done)
        voltage_ratio_percent <= volt_div_q;
      pos_seq_voltage_out <= pos_seq_voltage;
      neg_seq_voltage_out <= neg_seq_voltage;
      if (pos_seq_voltage < `MSP_VSEQ_MIN)
        voltage_seq_status <= `MSP_VSEQ_UNK;
      else if (neg_seq_voltage > pos_seq_voltage)
        voltage_seq_status <= `MSP_VSEQ_REV;
      else
        voltage_seq_status <= `MSP_VSEQ_OK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequence stage; with a 100 ms operate time one ms is one percent
  assign ps_cond = (ps_ratio_percent > `MSP_PS_RATIO_PCT) && !ps_blocked;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ps_start                 <= 1'b0;
      ps_trip                  <= 1'b0;
      ps_ms_q                  <= `MSP_ZERO16;
      ps_elapsed_delay_percent <= `MSP_ZERO16;
    end else if (!ps_cond) begin
      ps_start <= 1'b0;
      ps_trip  <= 1'b0;
      ps_ms_q  <= `MSP_ZERO16;
    end else begin
      ps_start <= 1'b1;
      if (tick_q && ps_ms_q < `MSP_PS_TRIP_MS)
        ps_ms_q <= ps_ms_q + `MSP_ONE16;
      if (ps_ms_q >= `MSP_PS_TRIP_MS)
        ps_trip <= 1'b1;
      ps_elapsed_delay_percent <= ps_ms_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stall stage
  assign stall_cond     = motor_starting && !stall_blocked &&
                          (motor_current >= `MSP_RUN_HI_PCT);
  assign cur_sq         = {48'h0000_0000_0000, motor_current} *
                          {48'h0000_0000_0000, motor_current};
  assign rated_sq_t     = {48'h0000_0000_0000, set_rated} *
                          {48'h0000_0000_0000, set_rated} *
                          {48'h0000_0000_0000, set_inv};
  assign stall_weighted = {48'h0000_0000_0000, stall_ms_q} * cur_sq;
  // Inverse form compares t*I^2 against Ist^2*Tstart to avoid a divide
  assign stall_due      = set_fixed ? (stall_ms_q >= set_dt) :
                          (stall_weighted >= rated_sq_t);
  assign stall_num      = set_fixed ?
                          {48'h0000_0000_0000, stall_ms_q} * `MSP_PCT_SCALE :
                          stall_weighted * `MSP_PCT_SCALE;
  assign stall_den      = set_fixed ? {48'h0000_0000_0000, set_dt} : rated_sq_t;

  msp_div u_stall_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (tick_q),
    .num     (stall_num),
    .den     (stall_den),
    .done    (stall_div_done),
    .quot    (stall_div_q)
  );

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      stall_start                 <= 1'b0;
      stall_trip                  <= 1'b0;
      stall_ms_q                  <= `MSP_ZERO16;
      stall_elapsed_delay_percent <= `MSP_ZERO16;
      measured_start_current      <= `MSP_ZERO16;
    end else if (!stall_cond) begin
      stall_start <= 1'b0;
      stall_trip  <= 1'b0;
      stall_ms_q  <= `MSP_ZERO16;
    end else begin
      stall_start            <= 1'b1;
      measured_start_current <= motor_current;
      if (tick_q && stall_ms_q != `MSP_PCT_SAT)
        stall_ms_q <= stall_ms_q + `MSP_ONE16;
      if (stall_due)
        stall_trip <= 1'b1;
      if (stall_div_done)
        stall_elapsed_delay_percent <= stall_div_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event counters, one pair per stage
  assign stage_start = {stall_start, ps_start};
  assign stage_trip  = {stall_trip, ps_trip};

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      start_prev_q <= 2'b00;
      trip_prev_q  <= 2'b00;
    end else begin
      start_prev_q <= stage_start;
      trip_prev_q  <= stage_trip;
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : cnt
      // An event in the clearing cycle is kept as the first count
      always @(posedge ref_clk) begin
        if (!reset_n) begin
          start_cnt_q[s] <= `MSP_ZERO16;
          trip_cnt_q[s]  <= `MSP_ZERO16;
        end else begin
          if (stage_start[s] && !start_prev_q[s])
            start_cnt_q[s] <= counter_clear ? `MSP_ONE16 : start_cnt_q[s] + `MSP_ONE16;
          else if (counter_clear)
            start_cnt_q[s] <= `MSP_ZERO16;
          if (stage_trip[s] && !trip_prev_q[s])
            trip_cnt_q[s] <= counter_clear ? `MSP_ONE16 : trip_cnt_q[s] + `MSP_ONE16;
          else if (counter_clear)
            trip_cnt_q[s] <= `MSP_ZERO16;
        end
      end
    end
  endgenerate

  assign ps_start_event_counter    = start_cnt_q[0];
  assign ps_trip_event_counter     = trip_cnt_q[0];
  assign stall_start_event_counter = start_cnt_q[1];
  assign stall_trip_event_counter  = trip_cnt_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Output matrix
  assign out_src = {stall_trip, stall_start, ps_trip, ps_start,
                    motor_running, motor_starting, motor_stopped};

  genvar r;
  generate
    for (r = 0; r < 4; r = r + 1) begin : rly
      always @(posedge ref_clk) begin
        if (!reset_n)
          output_relays[r] <= 1'b0;
        else
          output_relays[r] <= |(out_src & output_matrix_mask[r*7 +: 7]);
      end
    end
  endgenerate

endmodule

// ---- msp_top_props.sv ----
// Assertion checker for the motor start supervision top
`timescale 1ns/100ps
module msp_top_props #(
  parameter [31:0] TICK_CYCLES = 32'h0000_000A
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        reset_n,
  // Watched inputs
  input wire [15:0] motor_current,
  input wire [15:0] pos_seq_voltage,
  input wire        counter_clear,
  // Watched outputs
  input wire        motor_stopped,
  input wire        motor_starting,
  input wire        motor_running,
  input wire        ps_start,
  input wire        ps_trip,
  input wire [15:0] ps_ratio_percent,
  input wire [15:0] ps_start_event_counter,
  input wire        stall_start,
  input wire [1:0]  voltage_seq_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // ps_start run length bounds trip delay
  reg [31:0] ps_run_q;
  always @(posedge ref_clk) begin
    if (!reset_n || !ps_start)
      ps_run_q <= 32'h0000_0000;
    else
      ps_run_q <= ps_run_q + 32'h0000_0001;
  end
  sequence s_ps_rise;
    $rose(ps_start) && !counter_clear;
  endsequence
  sequence s_v_low;
    (pos_seq_voltage < 16'h0064) [*3];
  endsequence
  ////////////////////////////////////////
  a_state_one_hot: assert property ($onehot({motor_stopped, motor_starting, motor_running}))
    else $error("motor state not one-hot");
  a_stop_on_low: assert property ((motor_current < 16'h000A) |=> motor_stopped)
    else $error("low current did not give stopped");
  a_ps_start_ratio: assert property ($rose(ps_start) |-> $past(ps_ratio_percent) > 16'h0050)
    else $error("ps start without high ratio");
  a_ps_drop_low: assert property ((ps_ratio_percent <= 16'h0050) |=> !ps_start && !ps_trip)
    else $error("ps stage held with low ratio");
  a_ps_trip_delay: assert property ($rose(ps_trip) |->
      ps_run_q >= 99 * TICK_CYCLES && ps_run_q <= 101 * TICK_CYCLES)
    else $error("ps trip delay out of range");
  a_ps_count_step: assert property (s_ps_rise |=>
      ps_start_event_counter == $past(ps_start_event_counter) + 16'h0001)
    else $error("ps start counter did not step");
  a_stall_only_starting: assert property (stall_start |-> $past(motor_starting))
    else $error("stall active outside starting");
  a_stall_release: assert property (stall_start && motor_current < 16'h0078 |=> !stall_start)
    else $error("stall not released below limit");
  a_vseq_unknown: assert property (s_v_low |=> voltage_seq_status == 2'h2)
    else $error("low voltage not unknown");
endmodule
bind msp_top msp_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// ---- msp_fe_model.sv ----
// Measurement front end model
`timescale 1ns/100ps
module msp_fe_model (
  // Clock
  input  wire        ref_clk,
  // Quantities commanded by the bench
  input  wire [15:0] set_current,
  input  wire [15:0] set_neg_i,
  input  wire [15:0] set_pos_i,
  input  wire [15:0] set_pos_v,
  input  wire [15:0] set_neg_v,
  // Measured quantities
  output reg  [15:0] motor_current   = 16'h0000,
  output reg  [15:0] neg_seq_current = 16'h0000,
  output reg  [15:0] pos_seq_current = 16'h0000,
  output reg  [15:0] pos_seq_voltage = 16'h0000,
  output reg  [15:0] neg_seq_voltage = 16'h0000
);
  // One sample of latency, as a real filter adds
  always @(posedge ref_clk) begin
    motor_current   <= set_current;
    neg_seq_current <= set_neg_i;
    pos_seq_current <= set_pos_i;
    pos_seq_voltage <= set_pos_v;
    neg_seq_voltage <= set_neg_v;
  end
endmodule

// ---- msp_top_tb.sv ----
// Bench for the motor start supervision block
`timescale 1ns/100ps
module msp_top_tb;
  localparam [31:0] TK = 32'h0000_000A;
  reg        ref_clk = 1'b0;
  reg        reset_n = 1'b0;
  reg [15:0] i_mot = 16'h0000, i_neg = 16'h0000, i_pos = 16'h0064;
  reg [15:0] v_pos = 16'h0000, v_neg = 16'h0000;
  reg        cfg_wr_en = 1'b0, grp_sel_enable = 1'b0, counter_clear = 1'b0;
  reg [2:0]  cfg_field = 3'h0;
  reg [15:0] cfg_data = 16'h0000;
  reg [7:0]  digital_inputs = 8'h00;
  reg [14:0] ps_block_mask = 15'h0000;
  reg [27:0] output_matrix_mask = 28'h000_0000;
  wire [15:0] motor_current, neg_seq_current, pos_seq_current, pos_seq_voltage;
  wire [15:0] neg_seq_voltage, ps_ratio_percent, ps_start_event_counter, measured_start_current;
  wire [15:0] ps_trip_event_counter, ps_elapsed_delay_percent, voltage_ratio_percent;
  wire [15:0] stall_start_event_counter, stall_trip_event_counter, stall_elapsed_delay_percent;
  wire [15:0] pos_seq_voltage_out, neg_seq_voltage_out;
  wire        motor_stopped, motor_starting, motor_running, ps_start, ps_trip;
  wire        stall_start, stall_trip;
  wire [1:0]  active_group, voltage_seq_status;
  wire [3:0]  output_relays;
  int         n_fail = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  msp_fe_model fe (.*, .set_current(i_mot), .set_neg_i(i_neg), .set_pos_i(i_pos),
    .set_pos_v(v_pos), .set_neg_v(v_neg));
  msp_top #(.TICK_CYCLES(TK)) uut (.*, .cfg_group(2'h0), .grp_sel_input(3'h0),
    .grp_sel_target(2'h1), .virtual_inputs(4'h0), .stall_block_mask(15'h0000));
  ////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task cfg(input [2:0] f, input [15:0] d);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_field <= f;
    cfg_data  <= d;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk("stopped", 16'h0001, motor_stopped);
    chk("vseq", 16'h0002, voltage_seq_status);
    chk("group", 16'h0000, active_group);
    @(posedge ref_clk) grp_sel_enable <= 1'b1;
    digital_inputs <= 8'h01;
    cyc(3);
    chk("group sel", 16'h0001, active_group);
    @(posedge ref_clk) digital_inputs <= 8'h00;
    $display("t_reset done");
  endtask
  task t_dt;
    int n;
    cfg(3'h2, 16'h0014);
    cyc(5200);
    @(posedge ref_clk) i_mot <= 16'h028A;
    cyc(4);
    chk("starting", 16'h0001, motor_starting);
    n = 0;
    while (stall_trip !== 1'b1 && n < 400) begin cyc(1); n++; end
    chk("dt delay", 16'h0001, 16'(n >= 185 && n <= 215));
    cyc(2);
    chk("stall starts", 16'h0001, stall_start_event_counter);
    chk("stall trips", 16'h0001, stall_trip_event_counter);
    @(posedge ref_clk) i_mot <= 16'h0064;
    cyc(4);
    chk("running", 16'h0001, motor_running);
    chk("stall off", 16'h0000, stall_start);
    chk("meas cur", 16'h028A, measured_start_current);
    chk("stall elapsed_delay_percent", 16'h0001,
        16'(stall_elapsed_delay_percent inside {[16'h000A:16'h0064]}));
    $display("t_dt done");
  endtask
  task t_inv;
    int n;
    @(posedge ref_clk) i_mot <= 16'h0000;
    cfg(3'h4, 16'h0000);
    cfg(3'h3, 16'h000A);
    cfg(3'h0, 16'h00FA);
    cyc(3000);
    @(posedge ref_clk) i_mot <= 16'h012C;
    cyc(4);
    chk("early start", 16'h0000, motor_starting);
    @(posedge ref_clk) i_mot <= 16'h0000;
    cyc(5200);
    chk("stopped", 16'h0001, motor_stopped);
    @(posedge ref_clk) i_mot <= 16'h012C;
    cyc(4);
    chk("starting", 16'h0001, motor_starting);
    n = 0;
    while (stall_trip !== 1'b1 && n < 700) begin cyc(1); n++; end
    chk("inv delay", 16'h0001, 16'(n >= 385 && n <= 415));
    @(posedge ref_clk) i_mot <= 16'h0000;
    cyc(3);
    chk("stall off", 16'h0000, stall_start);
    $display("t_inv done");
  endtask
  task t_soft;
    logic s;
    s = 1'b0;
    cyc(5200);
    @(posedge ref_clk) i_mot <= 16'h0050;
    repeat (2300) begin cyc(1); if (motor_starting === 1'b1) s = 1'b1; end
    chk("skip start", 16'h0000, s);
    chk("soft run", 16'h0001, motor_running);
    $display("t_soft done");
  endtask
  task t_ps;
    int n;
    @(posedge ref_clk) output_matrix_mask <= 28'h000_0008;
    i_neg <= 16'h005A;
    n = 0;
    while (ps_start !== 1'b1 && n < 200) begin cyc(1); n++; end
    chk("ratio", 16'h005A, ps_ratio_percent);
    while (ps_trip !== 1'b1 && n < 1400) begin cyc(1); n++; end
    cyc(2);
    chk("ps trip", 16'h0001, ps_trip);
    chk("elapsed", 16'h0064, ps_elapsed_delay_percent);
    chk("relay", 16'h0001, output_relays);
    chk("ps trips", 16'h0001, ps_trip_event_counter);
    @(posedge ref_clk) digital_inputs <= 8'h02;
    ps_block_mask <= 15'h0002;
    cyc(3);
    chk("blocked", 16'h0000, ps_start);
    @(posedge ref_clk) i_neg <= 16'h0000;
    counter_clear <= 1'b1;
    @(posedge ref_clk) counter_clear <= 1'b0;
    cyc(200);
    chk("cleared", 16'h0000, ps_start_event_counter);
    chk("ps low", 16'h0000, ps_start);
    $display("t_ps done");
  endtask
  task t_v;
    @(posedge ref_clk) v_pos <= 16'h00C8;
    v_neg <= 16'h0032;
    cyc(150);
    chk("v ok", 16'h0000, voltage_seq_status);
    chk("v ratio", 16'h0019, voltage_ratio_percent);
    chk("v pos", 16'h00C8, pos_seq_voltage_out);
    chk("v neg", 16'h0032, neg_seq_voltage_out);
    @(posedge ref_clk) v_neg <= 16'h012C;
    cyc(150);
    chk("v rev", 16'h0001, voltage_seq_status);
    $display("t_v done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(2);
    t_reset;
    t_dt;
    t_inv;
    t_soft;
    t_ps;
    t_v;
    report_and_stop;
  end
  // Tests need about 23k cycles
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
endmodule
